// ==== hw/periph_map_defs.svh ====
/*
  Constants of the peripheral register window: data addresses, subaddresses,
  widths and reset values. Assumes it is included by its bare name and that
  all addresses are word addresses of the CPU data space.
*/
// Contract
// [R1] Port 0 receive word 2, word 1, transmit word 2, word 1 at 20h-23h.
// [R2] Port 1 receive word 2, word 1, transmit word 2, word 1 at 40h-43h.
// [R3] Wait states 28h, bank switch 29h, wait control 2Bh, 2Ah reserved.
// [R4] Pin control at 3Ch, pin status at 3Dh.
// [R5] DMA priority and enable register directly addressed at 54h.
// [R6] DMA pointer 55h, incrementing data port 56h, plain data port 57h.
// [R7] Every access through 56h advances the DMA pointer by one afterwards.
// [R8] Serial port 0 pointer/data at 38h/39h, port 1 at 48h/49h.
// [R9] A serial port pointer holds the subaddress of one control register.
// [R10] Indirect data reads the selected register; writes update only that one.
// [R11] Subaddresses 00h-05h: port control, receive control, transmit control 1 and 2.
// [R12] Subaddresses 06h-09h: sample rate generator 1,2 and multichannel 1,2.
// [R13] 0Ah-0Dh receive/transmit channel enables A,B; 0Eh pin control.
// [R14] Reserved addresses in 20h-5Fh read zero and ignore writes.
// [R15] Serial subaddress above 0Eh reads zero and ignores writes.
`ifndef PERIPH_MAP_DEFS_SVH
`define PERIPH_MAP_DEFS_SVH

// ============================================================
// Widths
`define PM_ADDR_W          16
`define PM_DATA_W          16
`define PM_NUM_DIRECT      21
`define PM_NUM_SER_CTRL    15
`define PM_RESET_WORD      16'h0000

// ============================================================
// Direct data addresses
`define PM_P0_RX_WORD2     16'h0020
`define PM_P0_RX_WORD1     16'h0021
`define PM_P0_TX_WORD2     16'h0022
`define PM_P0_TX_WORD1     16'h0023
`define PM_T0_COUNT        16'h0024
`define PM_T0_PERIOD       16'h0025
`define PM_T0_CONTROL      16'h0026
`define PM_BUS_WAIT_STATES 16'h0028
`define PM_BUS_BANK_SWITCH 16'h0029
`define PM_BUS_WAIT_CTRL   16'h002B
`define PM_HOST_PORT_CTRL  16'h002C
`define PM_T1_COUNT        16'h0030
`define PM_T1_PERIOD       16'h0031
`define PM_T1_CONTROL      16'h0032
`define PM_P0_IND_PTR      16'h0038
`define PM_P0_IND_DATA     16'h0039
`define PM_GP_PIN_CTRL     16'h003C
`define PM_GP_PIN_STATUS   16'h003D
`define PM_P1_RX_WORD2     16'h0040
`define PM_P1_RX_WORD1     16'h0041
`define PM_P1_TX_WORD2     16'h0042
`define PM_P1_TX_WORD1     16'h0043
`define PM_P1_IND_PTR      16'h0048
`define PM_P1_IND_DATA     16'h0049
`define PM_DMA_PRIO_EN     16'h0054
`define PM_DMA_IND_PTR     16'h0055
`define PM_DMA_IND_INCR    16'h0056
`define PM_DMA_IND_DATA    16'h0057
`define PM_CLOCK_MODE      16'h0058

// ============================================================
// Serial port subaddresses (ends of the control group)
`define PM_SUB_FIRST       16'h0000
`define PM_SUB_PIN_CTRL    16'h000E

`endif

// ==== hw/periph_map_pkg.sv ====
/*
  Types of the peripheral register window: the CPU request carrier and the
  DMA subbank write carrier. Assumes periph_map_defs.svh is on the include path.
*/
`include "periph_map_defs.svh"

package periph_map_pkg;

  // ============================================================
  // CPU data bus request, one access per cycle
  typedef struct packed {
    logic [`PM_ADDR_W-1:0] addr;
    logic                  rd;
    logic                  wr;
    logic [`PM_DATA_W-1:0] wdata;
  } cpu_req_t;

  // ============================================================
  // Write toward the DMA controller's subbank
  typedef struct packed {
    logic                  wr;
    logic [`PM_ADDR_W-1:0] addr;
    logic [`PM_DATA_W-1:0] wdata;
  } dma_sub_wr_t;

  typedef logic [`PM_NUM_DIRECT-1:0][`PM_DATA_W-1:0]                       direct_bank_t;
  typedef logic [1:0][`PM_NUM_SER_CTRL-1:0][`PM_DATA_W-1:0]                serial_bank_t;

endpackage

// ==== hw/peripheral_register_decoder.sv ====
/*
  Peripheral register window decoder: direct registers, the general-purpose
  pin status view, the two serial port pointer/data pairs with their control
  registers, and the DMA pointer with its two data ports.
  Assumes the CPU core on the same clock issues at most one read or write per
  cycle, and that the DMA controller answers its subbank read data
  combinationally from the pointer it is given.
*/
`timescale 1ns/10ps
`include "periph_map_defs.svh"

module peripheral_register_decoder (
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  input  wire periph_map_pkg::cpu_req_t    cpu_req,
  output      logic [`PM_DATA_W-1:0]       cpu_rdata_q,
  output      logic                        cpu_rvalid_q,
  input  wire logic [`PM_DATA_W-1:0]       gp_pin_in,
  output      periph_map_pkg::direct_bank_t direct_regs_q,
  output      periph_map_pkg::serial_bank_t serial_ctrl_q,
  output      logic [`PM_ADDR_W-1:0]       dma_indirect_pointer_q,
  input  wire logic [`PM_DATA_W-1:0]       dma_sub_rdata,
  output      periph_map_pkg::dma_sub_wr_t dma_sub_wr_q
);
  import periph_map_pkg::*;

  // ============================================================
  // Direct register slots
  // Only mapped registers get storage; the slot number is internal.
  function automatic logic [5:0] direct_slot(input logic [`PM_ADDR_W-1:0] a);
    logic [5:0] s;
    s = 6'h3F;
    unique case (a)
      `PM_P0_RX_WORD2:     s = 6'h00; // [R1]
      `PM_P0_RX_WORD1:     s = 6'h01; // [R1]
      `PM_P0_TX_WORD2:     s = 6'h02; // [R1]
      `PM_P0_TX_WORD1:     s = 6'h03; // [R1]
      `PM_T0_COUNT:        s = 6'h04;
      `PM_T0_PERIOD:       s = 6'h05;
      `PM_T0_CONTROL:      s = 6'h06;
      `PM_BUS_WAIT_STATES: s = 6'h07; // [R3]
      `PM_BUS_BANK_SWITCH: s = 6'h08; // [R3]
      `PM_BUS_WAIT_CTRL:   s = 6'h09; // [R3]
      `PM_HOST_PORT_CTRL:  s = 6'h0A;
      `PM_T1_COUNT:        s = 6'h0B;
      `PM_T1_PERIOD:       s = 6'h0C;
      `PM_T1_CONTROL:      s = 6'h0D;
      `PM_GP_PIN_CTRL:     s = 6'h0E; // [R4]
      `PM_P1_RX_WORD2:     s = 6'h0F; // [R2]
      `PM_P1_RX_WORD1:     s = 6'h10; // [R2]
      `PM_P1_TX_WORD2:     s = 6'h11; // [R2]
      `PM_P1_TX_WORD1:     s = 6'h12; // [R2]
      `PM_DMA_PRIO_EN:     s = 6'h13; // [R5]
      `PM_CLOCK_MODE:      s = 6'h14;
      default:             s = 6'h3F; // Reserved or outside the window [R14]
    endcase
    return s;
  endfunction

  // ============================================================
  // Pin input synchroniser
  logic [`PM_DATA_W-1:0] gp_meta_q;
  logic [`PM_DATA_W-1:0] gp_sync_q;

  // Pins are asynchronous; only the second stage is read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gp_meta_q <= `PM_RESET_WORD;
      gp_sync_q <= `PM_RESET_WORD;
    end else begin
      gp_meta_q <= gp_pin_in;
      gp_sync_q <= gp_meta_q;
    end
  end

  // ============================================================
  // Address decode
  logic [5:0] slot;
  logic       hit_direct;
  logic       hit_gp_status;
  logic       hit_sp_ptr;
  logic       hit_sp_data;
  logic       sp_sel;
  logic       hit_dma_ptr;
  logic       hit_dma_incr;
  logic       hit_dma_data;
  logic       hit_dma_port;

  assign slot          = direct_slot(cpu_req.addr);
  assign hit_direct    = (slot < 6'(`PM_NUM_DIRECT));
  assign hit_gp_status = (cpu_req.addr == `PM_GP_PIN_STATUS);                     // [R4]
  assign hit_sp_ptr    = (cpu_req.addr == `PM_P0_IND_PTR)
                      || (cpu_req.addr == `PM_P1_IND_PTR);                        // [R8]
  assign hit_sp_data   = (cpu_req.addr == `PM_P0_IND_DATA)
                      || (cpu_req.addr == `PM_P1_IND_DATA);                       // [R8]
  // Port 1 pair sits in the upper half of the window
  assign sp_sel        = (cpu_req.addr == `PM_P1_IND_PTR)
                      || (cpu_req.addr == `PM_P1_IND_DATA);
  assign hit_dma_ptr   = (cpu_req.addr == `PM_DMA_IND_PTR);                       // [R6]
  assign hit_dma_incr  = (cpu_req.addr == `PM_DMA_IND_INCR);                      // [R6]
  assign hit_dma_data  = (cpu_req.addr == `PM_DMA_IND_DATA);                      // [R6]
  assign hit_dma_port  = hit_dma_incr || hit_dma_data;

  // ============================================================
  // Serial port indirect selection
  logic [1:0][`PM_ADDR_W-1:0] sp_ptr_q;
  logic [`PM_ADDR_W-1:0]      sp_sub;
  logic                       sp_sub_ok;
  logic [3:0]                 sp_idx;

  // The pointer of the addressed port picks one control register [R9]
  assign sp_sub    = sp_ptr_q[sp_sel];
  // Subaddresses past pin control reach nothing [R15]
  assign sp_sub_ok = (sp_sub <= `PM_SUB_PIN_CTRL);
  // Subaddress equals the slot index: 00h-05h port/rx/tx control [R11],
  // 06h-09h rate generator and multichannel [R12], 0Ah-0Eh enables and pins [R13]
  assign sp_idx    = sp_sub[3:0];

  // ============================================================
  // Write strobes
  logic wr_direct;
  logic wr_sp_ptr;
  logic wr_sp_data;
  logic wr_dma_ptr;
  logic dma_port_acc;

  assign wr_direct    = cpu_req.wr && hit_direct;                                 // [R14]
  assign wr_sp_ptr    = cpu_req.wr && hit_sp_ptr;
  assign wr_sp_data   = cpu_req.wr && hit_sp_data && sp_sub_ok;                   // [R10] [R15]
  assign wr_dma_ptr   = cpu_req.wr && hit_dma_ptr;
  // Any read or write through the incrementing port counts
  assign dma_port_acc = (cpu_req.rd || cpu_req.wr) && hit_dma_incr;

  // ============================================================
  // Read data selection
  logic [`PM_DATA_W-1:0] rd_mux;
  logic [`PM_DATA_W-1:0] rd_direct;
  logic [`PM_DATA_W-1:0] rd_serial;

  assign rd_direct = hit_direct ? direct_regs_q[slot[4:0]] : `PM_RESET_WORD;
  assign rd_serial = sp_sub_ok ? serial_ctrl_q[sp_sel][sp_idx] : `PM_RESET_WORD;  // [R10] [R15]
  // Everything not decoded falls through to zero [R14]
  assign rd_mux    = hit_direct    ? rd_direct :
                     hit_gp_status ? gp_sync_q :                                  // [R4]
                     hit_sp_ptr    ? sp_sub :
                     hit_sp_data   ? rd_serial :
                     hit_dma_ptr   ? dma_indirect_pointer_q :
                     hit_dma_port  ? dma_sub_rdata :
                     `PM_RESET_WORD;

  // ============================================================
  // Read answer, registered one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cpu_rdata_q  <= `PM_RESET_WORD;
      cpu_rvalid_q <= 1'b0;
    end else begin
      cpu_rvalid_q <= cpu_req.rd;
      cpu_rdata_q  <= cpu_req.rd ? rd_mux : `PM_RESET_WORD;
    end
  end

  // ============================================================
  // Direct registers
  // Peripherals are modelled as holding copies here; their own updates
  // of count or receive words are outside this block.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      direct_regs_q <= '0;
    end else if (wr_direct) begin
      direct_regs_q[slot[4:0]] <= cpu_req.wdata;                                  // [R1] [R2] [R3] [R5]
    end
  end

  // ============================================================
  // Serial port pointers and control registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sp_ptr_q <= '0;
    end else if (wr_sp_ptr) begin
      sp_ptr_q[sp_sel] <= cpu_req.wdata;                                          // [R8] [R9]
    end
  end

  // Only the register the pointer selects changes [R10]
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_ctrl_q <= '0;
    end else if (wr_sp_data) begin
      serial_ctrl_q[sp_sel][sp_idx] <= cpu_req.wdata;                             // [R10]
    end
  end

  // ============================================================
  // DMA pointer
  // A pointer write wins over an increment; they cannot meet anyway,
  // since one request carries one address.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dma_indirect_pointer_q <= `PM_RESET_WORD;
    end else if (wr_dma_ptr) begin
      dma_indirect_pointer_q <= cpu_req.wdata;                                    // [R6]
    end else if (dma_port_acc) begin
      dma_indirect_pointer_q <= dma_indirect_pointer_q + 16'h0001;                // [R7]
    end
  end

  // ============================================================
  // DMA subbank write, one cycle after the CPU write
  // Address is captured before the increment so the write lands on
  // the register the access named.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dma_sub_wr_q <= '0;
    end else begin
      dma_sub_wr_q.wr    <= cpu_req.wr && hit_dma_port;                           // [R6]
      dma_sub_wr_q.addr  <= dma_indirect_pointer_q;
      dma_sub_wr_q.wdata <= cpu_req.wdata;
    end
  end

endmodule

// ==== verification/dma_subbank_model.sv ====
/*
  Stand-in for the DMA controller's subbank: forty words behind the pointer.
  Assumes the decoder's pointer output and its one-cycle write pulse.
*/
`timescale 1ns/10ps
`include "periph_map_defs.svh"
module dma_subbank_model (
  input  wire logic                        sys_clk,
  input  wire logic [`PM_ADDR_W-1:0]       ptr,
  input  wire periph_map_pkg::dma_sub_wr_t wr_in,
  output      logic [`PM_DATA_W-1:0]       rdata
);
  import periph_map_pkg::*;
  // ============================================================
  // Storage; subaddresses past 27h hold nothing, so they answer zero
  logic [`PM_DATA_W-1:0] mem_q [40];
  assign rdata = (ptr < 16'h0028) ? mem_q[ptr[5:0]] : 16'h0000;
  always_ff @(posedge sys_clk) begin
    if (wr_in.wr && wr_in.addr < 16'h0028) begin
      mem_q[wr_in.addr[5:0]] <= wr_in.wdata;
    end
  end
endmodule

// ==== verification/periph_map_properties.sv ====
/*
  Concurrent checks on the decoder's ports.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "periph_map_defs.svh"
module periph_map_properties (
  input wire logic                         sys_clk,
  input wire logic                         sys_rst,
  input wire periph_map_pkg::cpu_req_t     cpu_req,
  input wire logic [`PM_DATA_W-1:0]        cpu_rdata_q,
  input wire logic                         cpu_rvalid_q,
  input wire logic [`PM_DATA_W-1:0]        gp_pin_in,
  input wire periph_map_pkg::direct_bank_t direct_regs_q,
  input wire logic [`PM_ADDR_W-1:0]        dma_indirect_pointer_q,
  input wire logic [`PM_DATA_W-1:0]        dma_sub_rdata,
  input wire periph_map_pkg::dma_sub_wr_t  dma_sub_wr_q
);
  import periph_map_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ============================================================
  // Request shorthands; pins must settle through two sync flops
  wire logic wr_c = cpu_req.wr;
  wire logic [15:0] a_c = cpu_req.addr;
  sequence pins_settled;
    $stable(gp_pin_in) [*4];
  endsequence
  sequence status_read;
    cpu_req.rd && a_c == `PM_GP_PIN_STATUS;
  endsequence
  AST_READ_ANSWER: assert property (cpu_req.rd |=> cpu_rvalid_q) else $error("read not answered");
  AST_P0_MAP: assert property (wr_c && a_c == `PM_P0_RX_WORD2
    |=> direct_regs_q[0] == $past(cpu_req.wdata)) else $error("port 0 word map wrong");
  AST_P1_MAP: assert property (wr_c && a_c == `PM_P1_TX_WORD1
    |=> direct_regs_q[18] == $past(cpu_req.wdata)) else $error("port 1 word map wrong");
  AST_BUS_MAP: assert property (wr_c && a_c == `PM_BUS_WAIT_CTRL
    |=> direct_regs_q[9] == $past(cpu_req.wdata)) else $error("wait control map wrong");
  AST_PIN_STATUS: assert property (pins_settled ##0 status_read
    |=> cpu_rdata_q == $past(gp_pin_in)) else $error("pin status wrong");
  AST_PRIO_MAP: assert property (wr_c && a_c == `PM_DMA_PRIO_EN
    |=> direct_regs_q[19] == $past(cpu_req.wdata)) else $error("dma priority map wrong");
  AST_DMA_INCR: assert property ((cpu_req.rd || wr_c) && a_c == `PM_DMA_IND_INCR
    |=> dma_indirect_pointer_q == $past(dma_indirect_pointer_q) + 16'h0001) else $error("no increment");
  AST_DMA_HOLD: assert property ((cpu_req.rd || wr_c) && a_c == `PM_DMA_IND_DATA
    |=> $stable(dma_indirect_pointer_q)) else $error("pointer moved");
  AST_DMA_WRITE: assert property (wr_c && a_c == `PM_DMA_IND_DATA
    |=> dma_sub_wr_q.wr && dma_sub_wr_q.addr == $past(dma_indirect_pointer_q)
    && dma_sub_wr_q.wdata == $past(cpu_req.wdata)) else $error("subbank write wrong");
  AST_DMA_READ: assert property (cpu_req.rd && a_c == `PM_DMA_IND_DATA
    |=> cpu_rdata_q == $past(dma_sub_rdata)) else $error("subbank read wrong");
  AST_RESERVED_ZERO: assert property (cpu_req.rd && (a_c == 16'h0027 || a_c == 16'h005F)
    |=> cpu_rdata_q == 16'h0000) else $error("reserved read not zero");
endmodule
bind peripheral_register_decoder periph_map_properties periph_map_properties_inst (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_rdata_q(cpu_rdata_q), .cpu_rvalid_q(cpu_rvalid_q),
  .gp_pin_in(gp_pin_in), .direct_regs_q(direct_regs_q), .dma_indirect_pointer_q(dma_indirect_pointer_q),
  .dma_sub_rdata(dma_sub_rdata), .dma_sub_wr_q(dma_sub_wr_q));

// ==== verification/tb_top.sv ====
/*
  Self-checking bench for the peripheral register window.
  Assumes the decoder and the DMA subbank model share sys_clk.
*/
`timescale 1ns/10ps
`include "periph_map_defs.svh"
module tb_top;
  import periph_map_pkg::*;
  logic sys_clk;
  logic sys_rst;
  cpu_req_t req;
  logic [15:0] rdata_q, gp_pins, ptr_q, sub_rdata;
  logic rvalid_q;
  direct_bank_t dregs_q;
  serial_bank_t sregs_q;
  dma_sub_wr_t sub_wr_q;
  int errors = 0;
  int compares = 0;
  // Direct addresses in slot order of the stored bank
  logic [15:0] dir_a [21] = '{16'h0020, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0025, 16'h0026, 16'h0028,
    16'h0029, 16'h002B, 16'h002C, 16'h0030, 16'h0031, 16'h0032, 16'h003C, 16'h0040, 16'h0041, 16'h0042,
    16'h0043, 16'h0054, 16'h0058};
  logic [15:0] rsv_a [10] = '{16'h0027, 16'h002A, 16'h002D, 16'h0033, 16'h003A, 16'h003E, 16'h0044, 16'h004A,
    16'h0059, 16'h005F};
  peripheral_register_decoder peripheral_register_decoder_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cpu_req(req), .cpu_rdata_q(rdata_q), .cpu_rvalid_q(rvalid_q), .gp_pin_in(gp_pins),
    .direct_regs_q(dregs_q), .serial_ctrl_q(sregs_q), .dma_indirect_pointer_q(ptr_q),
    .dma_sub_rdata(sub_rdata), .dma_sub_wr_q(sub_wr_q));
  dma_subbank_model dma_subbank_model_inst (.sys_clk(sys_clk), .ptr(ptr_q), .wr_in(sub_wr_q), .rdata(sub_rdata));
  // ============================================================
  // Clock, comparison and bus tasks
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk) req <= {a, 2'b01, d};
    @(posedge sys_clk) req <= '0;
  endtask
  // Answer stands one cycle only, so it is looked at just after that edge
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk) req <= {a, 2'b10, 16'h0000};
    @(posedge sys_clk) req <= '0;
    #1 chk({15'h0000, rvalid_q}, 16'h0001);
    chk(rdata_q, exp);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop;
  end
  // ============================================================
  // Main sequence
  initial begin
    req = '0;
    gp_pins = 16'h5A3C;
    sys_rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Direct map: zero after reset, then a distinct word per slot
    foreach (dir_a[i]) rd(dir_a[i], 16'h0000);
    foreach (dir_a[i]) wr(dir_a[i], 16'hA000 + 16'(i));
    foreach (dir_a[i]) rd(dir_a[i], 16'hA000 + 16'(i));
    foreach (dir_a[i]) chk(dregs_q[i], 16'hA000 + 16'(i));
    $display("Test direct map done");
    // Reserved places and the read-only pin status
    foreach (rsv_a[i]) wr(rsv_a[i], 16'hFFFF);
    foreach (rsv_a[i]) rd(rsv_a[i], 16'h0000);
    foreach (dir_a[i]) chk(dregs_q[i], 16'hA000 + 16'(i));
    wr(`PM_GP_PIN_STATUS, 16'h0000);
    rd(`PM_GP_PIN_STATUS, 16'h5A3C);
    // A pin change shows only once both sync stages have taken it
    @(posedge sys_clk) gp_pins <= 16'hA5C3;
    rd(`PM_GP_PIN_STATUS, 16'h5A3C);
    rd(`PM_GP_PIN_STATUS, 16'hA5C3);
    $display("Test reserved done");
    // Serial control groups: every subaddress of both ports
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 15; s++) begin
        wr(p ? `PM_P1_IND_PTR : `PM_P0_IND_PTR, 16'(s));
        wr(p ? `PM_P1_IND_DATA : `PM_P0_IND_DATA, 16'hC000 + 16'(p * 256 + s));
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 15; s++) begin
        wr(p ? `PM_P1_IND_PTR : `PM_P0_IND_PTR, 16'(s));
        rd(p ? `PM_P1_IND_PTR : `PM_P0_IND_PTR, 16'(s));
        rd(p ? `PM_P1_IND_DATA : `PM_P0_IND_DATA, 16'hC000 + 16'(p * 256 + s));
        chk(sregs_q[p][s], 16'hC000 + 16'(p * 256 + s));
      end
    end
    // Subaddress past pin control, small and with top bits set
    wr(`PM_P0_IND_PTR, 16'h000F);
    wr(`PM_P0_IND_DATA, 16'h1234);
    rd(`PM_P0_IND_DATA, 16'h0000);
    wr(`PM_P0_IND_PTR, 16'h010E);
    wr(`PM_P0_IND_DATA, 16'h1234);
    rd(`PM_P0_IND_DATA, 16'h0000);
    chk(sregs_q[0][14], 16'hC00E);
    $display("Test serial groups done");
    // DMA subbank: incrementing and plain ports, with an idle cycle between accesses
    wr(`PM_DMA_IND_PTR, 16'h0003);
    wr(`PM_DMA_IND_INCR, 16'hD000);
    wr(`PM_DMA_IND_INCR, 16'hD001);
    rd(`PM_DMA_IND_PTR, 16'h0005);
    wr(`PM_DMA_IND_DATA, 16'hD002);
    rd(`PM_DMA_IND_DATA, 16'hD002);
    rd(`PM_DMA_IND_PTR, 16'h0005);
    wr(`PM_DMA_IND_PTR, 16'h0003);
    rd(`PM_DMA_IND_INCR, 16'hD000);
    rd(`PM_DMA_IND_INCR, 16'hD001);
    rd(`PM_DMA_IND_PTR, 16'h0005);
    $display("Test dma subbank done");
    // Mid-run reset clears pointers and stored registers
    @(posedge sys_clk) sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`PM_DMA_IND_PTR, 16'h0000);
    rd(`PM_P1_IND_PTR, 16'h0000);
    chk(dregs_q[19], 16'h0000);
    chk(sregs_q[0][14], 16'h0000);
    $display("Test mid-run reset done");
    report_and_stop;
  end
endmodule
